// ### logic/arith_est_map.vh
// constants for the arithmetic encoder estimation and renormalization block
// Operation
// [RULE1] fixed 113-state estimator table: probability, two successors, flip flag; state 0 is 5A1D
// [RULE2] a context's state changes only when a renormalization follows its decision
// [RULE3] renormalize after every LPS; after an MPS only if interval below 8000
// [RULE4] LPS renormalization loads the LPS successor of the old state
// [RULE5] MPS renormalization loads the MPS successor; MPS sense stays unchanged
// [RULE6] after an LPS, a set flip flag of the old state inverts the sense
// [RULE7] new state is written back to the selected context location
// [RULE8] renormalization shifts interval and code registers left together, one bit a step
// [RULE9] shift counter reaching zero hands one byte out and reloads 8
// [RULE10] shifting repeats until the interval is no longer below 8000
// [RULE11] initialization gives every context sense zero and state zero
// [RULE12] initialization clears code, sets interval 10000 and shift counter 11
// [RULE13] LPS adds interval minus estimate to code, interval becomes estimate; MPS keeps difference
// [RULE14] one read-modify-write per decision so the next decision sees the update
`ifndef ARITH_EST_MAP_VH
`define ARITH_EST_MAP_VH

`define CTX_W 6
`define CTX_NUM 64
`define IDX_W 7
`define PROB_W 15
`define A_W 17
`define C_W 28
`define SHIFT_CNT_W 4

`define STATE0_PROB 15'h5A1D
`define A_INIT 17'h10000
`define A_HALF 17'h08000
`define C_INIT 28'h0000000
`define SHIFT_CNT_INIT 4'hB
`define SHIFT_CNT_RELOAD 4'h8
`define CTX_INIT_STATE 7'h00
`define CTX_INIT_MPS 1'b0

`define BYTE_MSB 27
`define BYTE_LSB 19

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INTERVAL 8'h08
`define REG_CODE 8'h0C
`define REG_PEEK 8'h10

`define CTRL_INIT_BIT 0
`define CTRL_EN_BIT 1
`define CTRL_RESET 1'b0
`define STATUS_BUSY_BIT 0
`define STATUS_EN_BIT 1
`define STATUS_SHIFT_LSB 8
`define PEEK_MPS_BIT 8

`endif

// ### logic/ctx_store.v
// per-context estimator state and MPS sense storage
`timescale 1ns/1ps
`default_nettype none
`include "arith_est_map.vh"
module ctx_store (
  input wire sys_clk,
  input wire resetn,
  input wire clear,
  input wire we,
  input wire [`CTX_W-1:0] waddr,
  input wire [`IDX_W-1:0] wstate,
  input wire wmps,
  input wire [`CTX_W-1:0] raddr,
  output wire [`IDX_W-1:0] rstate,
  output wire rmps,
  input wire [`CTX_W-1:0] paddr_peek,
  output wire [`IDX_W:0] peek_data
);
  wire [`IDX_W:0] entry [0:`CTX_NUM-1];

  genvar g;
  generate
    for (g = 0; g < `CTX_NUM; g = g + 1) begin : slot
      reg [`IDX_W:0] cell_r;
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          cell_r <= {`CTX_INIT_MPS, `CTX_INIT_STATE}; // [RULE11]
        end else if (clear) begin
          cell_r <= {`CTX_INIT_MPS, `CTX_INIT_STATE}; // [RULE11]
        end else if (we && {{(32-`CTX_W){1'b0}}, waddr} == g) begin
          cell_r <= {wmps, wstate}; // [RULE7]
        end
      end
      assign entry[g] = cell_r;
    end
  endgenerate

  // read is combinational so the updated value is visible on the very next decision
  assign rstate = entry[raddr][`IDX_W-1:0]; // [RULE14]
  assign rmps = entry[raddr][`IDX_W];
  assign peek_data = entry[paddr_peek];
endmodule
`default_nettype wire

// ### logic/arith_est_renorm.v
// probability estimation and encoder renormalization with APB control
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "arith_est_map.vh"
module arith_est_renorm (
  input wire sys_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire dec_valid,
  output wire dec_ready,
  input wire [`CTX_W-1:0] dec_ctx,
  input wire dec_bit,
  output reg byte_valid,
  output reg [8:0] byte_data
);
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_RENORM = 2'b10;

  // entry layout: {sense_flip_flag, lps_probability_estimate, successor_on_lps, successor_on_mps}
  function [29:0] est_entry;
    input [`IDX_W-1:0] idx;
    reg [29:0] e;
    begin
      e = 30'h00000000;
      case (idx)
        7'h00:e={1'b1,`STATE0_PROB,7'h01,7'h01};
        7'h01:e={1'b0,15'h2586,7'h0E,7'h02};
        7'h02:e={1'b0,15'h1114,7'h10,7'h03};
        7'h03:e={1'b0,15'h080B,7'h12,7'h04};
        7'h04:e={1'b0,15'h03D8,7'h14,7'h05};
        7'h05:e={1'b0,15'h01DA,7'h17,7'h06};
        7'h06:e={1'b0,15'h00E5,7'h19,7'h07};
        7'h07:e={1'b0,15'h006F,7'h1C,7'h08};
        7'h08:e={1'b0,15'h0036,7'h1E,7'h09};
        7'h09:e={1'b0,15'h001A,7'h21,7'h0A};
        7'h0A:e={1'b0,15'h000D,7'h23,7'h0B};
        7'h0B:e={1'b0,15'h0006,7'h09,7'h0C};
        7'h0C:e={1'b0,15'h0003,7'h0A,7'h0D};
        7'h0D:e={1'b0,15'h0001,7'h0C,7'h0D};
        7'h0E:e={1'b1,15'h5A7F,7'h0F,7'h0F};
        7'h0F:e={1'b0,15'h3F25,7'h24,7'h10};
        7'h10:e={1'b0,15'h2CF2,7'h26,7'h11};
        7'h11:e={1'b0,15'h207C,7'h27,7'h12};
        7'h12:e={1'b0,15'h17B9,7'h28,7'h13};
        7'h13:e={1'b0,15'h1182,7'h2A,7'h14};
        7'h14:e={1'b0,15'h0CEF,7'h2B,7'h15};
        7'h15:e={1'b0,15'h09A1,7'h2D,7'h16};
        7'h16:e={1'b0,15'h072F,7'h2E,7'h17};
        7'h17:e={1'b0,15'h055C,7'h30,7'h18};
        7'h18:e={1'b0,15'h0406,7'h31,7'h19};
        7'h19:e={1'b0,15'h0303,7'h33,7'h1A};
        7'h1A:e={1'b0,15'h0240,7'h34,7'h1B};
        7'h1B:e={1'b0,15'h01B1,7'h36,7'h1C};
        7'h1C:e={1'b0,15'h0144,7'h38,7'h1D};
        7'h1D:e={1'b0,15'h00F5,7'h39,7'h1E};
        7'h1E:e={1'b0,15'h00B7,7'h3B,7'h1F};
        7'h1F:e={1'b0,15'h008A,7'h3C,7'h20};
        7'h20:e={1'b0,15'h0068,7'h3E,7'h21};
        7'h21:e={1'b0,15'h004E,7'h3F,7'h22};
        7'h22:e={1'b0,15'h003B,7'h20,7'h23};
        7'h23:e={1'b0,15'h002C,7'h21,7'h09};
        7'h24:e={1'b1,15'h5AE1,7'h25,7'h25};
        7'h25:e={1'b0,15'h484C,7'h40,7'h26};
        7'h26:e={1'b0,15'h3A0D,7'h41,7'h27};
        7'h27:e={1'b0,15'h2EF1,7'h43,7'h28};
        7'h28:e={1'b0,15'h261F,7'h44,7'h29};
        7'h29:e={1'b0,15'h1F33,7'h45,7'h2A};
        7'h2A:e={1'b0,15'h19A8,7'h46,7'h2B};
        7'h2B:e={1'b0,15'h1518,7'h48,7'h2C};
        7'h2C:e={1'b0,15'h1177,7'h49,7'h2D};
        7'h2D:e={1'b0,15'h0E74,7'h4A,7'h2E};
        7'h2E:e={1'b0,15'h0BFB,7'h4B,7'h2F};
        7'h2F:e={1'b0,15'h09F8,7'h4D,7'h30};
        7'h30:e={1'b0,15'h0861,7'h4E,7'h31};
        7'h31:e={1'b0,15'h0706,7'h4F,7'h32};
        7'h32:e={1'b0,15'h05CD,7'h30,7'h33};
        7'h33:e={1'b0,15'h04DE,7'h32,7'h34};
        7'h34:e={1'b0,15'h040F,7'h32,7'h35};
        7'h35:e={1'b0,15'h0363,7'h33,7'h36};
        7'h36:e={1'b0,15'h02D4,7'h34,7'h37};
        7'h37:e={1'b0,15'h025C,7'h35,7'h38};
        7'h38:e={1'b0,15'h01F8,7'h36,7'h39};
        7'h39:e={1'b0,15'h01A4,7'h37,7'h3A};
        7'h3A:e={1'b0,15'h0160,7'h38,7'h3B};
        7'h3B:e={1'b0,15'h0125,7'h39,7'h3C};
        7'h3C:e={1'b0,15'h00F6,7'h3A,7'h3D};
        7'h3D:e={1'b0,15'h00CB,7'h3B,7'h3E};
        7'h3E:e={1'b0,15'h00AB,7'h3D,7'h3F};
        7'h3F:e={1'b0,15'h008F,7'h3D,7'h20};
        7'h40:e={1'b1,15'h5B12,7'h41,7'h41};
        7'h41:e={1'b0,15'h4D04,7'h50,7'h42};
        7'h42:e={1'b0,15'h412C,7'h51,7'h43};
        7'h43:e={1'b0,15'h37D8,7'h52,7'h44};
        7'h44:e={1'b0,15'h2FE8,7'h53,7'h45};
        7'h45:e={1'b0,15'h293C,7'h54,7'h46};
        7'h46:e={1'b0,15'h2379,7'h56,7'h47};
        7'h47:e={1'b0,15'h1EDF,7'h57,7'h48};
        7'h48:e={1'b0,15'h1AA9,7'h57,7'h49};
        7'h49:e={1'b0,15'h174E,7'h48,7'h4A};
        7'h4A:e={1'b0,15'h1424,7'h48,7'h4B};
        7'h4B:e={1'b0,15'h119C,7'h4A,7'h4C};
        7'h4C:e={1'b0,15'h0F6B,7'h4A,7'h4D};
        7'h4D:e={1'b0,15'h0D51,7'h4B,7'h4E};
        7'h4E:e={1'b0,15'h0BB6,7'h4D,7'h4F};
        7'h4F:e={1'b0,15'h0A40,7'h4D,7'h30};
        7'h50:e={1'b1,15'h5832,7'h50,7'h51};
        7'h51:e={1'b0,15'h4D1C,7'h58,7'h52};
        7'h52:e={1'b0,15'h438E,7'h59,7'h53};
        7'h53:e={1'b0,15'h3BDD,7'h5A,7'h54};
        7'h54:e={1'b0,15'h34EE,7'h5B,7'h55};
        7'h55:e={1'b0,15'h2EAE,7'h5C,7'h56};
        7'h56:e={1'b0,15'h299A,7'h5D,7'h57};
        7'h57:e={1'b0,15'h2516,7'h56,7'h47};
        7'h58:e={1'b1,15'h5570,7'h58,7'h59};
        7'h59:e={1'b0,15'h4CA9,7'h5F,7'h5A};
        7'h5A:e={1'b0,15'h44D9,7'h60,7'h5B};
        7'h5B:e={1'b0,15'h3E22,7'h61,7'h5C};
        7'h5C:e={1'b0,15'h3824,7'h63,7'h5D};
        7'h5D:e={1'b0,15'h32B4,7'h63,7'h5E};
        7'h5E:e={1'b0,15'h2E17,7'h5D,7'h56};
        7'h5F:e={1'b1,15'h56A8,7'h5F,7'h60};
        7'h60:e={1'b0,15'h4F46,7'h65,7'h61};
        7'h61:e={1'b0,15'h47E5,7'h66,7'h62};
        7'h62:e={1'b0,15'h41CF,7'h67,7'h63};
        7'h63:e={1'b0,15'h3C3D,7'h68,7'h64};
        7'h64:e={1'b0,15'h375E,7'h63,7'h5D};
        7'h65:e={1'b0,15'h5231,7'h69,7'h66};
        7'h66:e={1'b0,15'h4C0F,7'h6A,7'h67};
        7'h67:e={1'b0,15'h4639,7'h6B,7'h68};
        7'h68:e={1'b0,15'h415E,7'h67,7'h63};
        7'h69:e={1'b1,15'h5627,7'h69,7'h6A};
        7'h6A:e={1'b0,15'h50E7,7'h6C,7'h6B};
        7'h6B:e={1'b0,15'h4B85,7'h6D,7'h67};
        7'h6C:e={1'b0,15'h5597,7'h6E,7'h6D};
        7'h6D:e={1'b0,15'h504F,7'h6F,7'h6B};
        7'h6E:e={1'b1,15'h5A10,7'h6E,7'h6F};
        7'h6F:e={1'b0,15'h5522,7'h70,7'h6D};
        7'h70:e={1'b1,15'h59EB,7'h70,7'h6F};
        // states above 112 never get stored; park them on the last state
        default:e={1'b1,15'h59EB,7'h70,7'h6F};
      endcase
      est_entry = e; // [RULE1]
    end
  endfunction

  reg [1:0] state_r;
  reg [`A_W-1:0] interval_r;
  reg [`C_W-1:0] code_r;
  reg [`SHIFT_CNT_W-1:0] shift_counter_r;
  reg enable_r;
  reg init_pend_r;
  reg [`CTX_W-1:0] peek_sel_r;

  wire [`IDX_W-1:0] ctx_state;
  wire context_mps_sense;
  wire [`IDX_W:0] peek_data;

  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire init_now = init_pend_r;

  // address match shared by the write strobes below
  function reg_hit;
    input [7:0] a;
    input [7:0] reg_addr;
    begin
      reg_hit = (a == reg_addr);
    end
  endfunction

  wire wr_ctrl = apb_wr & reg_hit(paddr, `REG_CTRL);
  wire wr_peek = apb_wr & reg_hit(paddr, `REG_PEEK);

  // decisions are held off while a renormalization runs or an init is pending
  assign dec_ready = state_r[0] & enable_r & ~init_pend_r;
  wire accept = dec_valid & dec_ready;

  wire [29:0] cur_entry = est_entry(ctx_state);
  wire sense_flip_flag = cur_entry[29];
  wire [`PROB_W-1:0] lps_probability_estimate = cur_entry[28:14];
  wire [`IDX_W-1:0] successor_on_lps = cur_entry[13:7];
  wire [`IDX_W-1:0] successor_on_mps = cur_entry[6:0];

  wire is_lps = dec_bit ^ context_mps_sense;
  wire [`A_W-1:0] a_diff = interval_r - {2'b00, lps_probability_estimate};
  wire [`C_W-1:0] c_add = code_r + {{(`C_W-`A_W){1'b0}}, a_diff};

  // state moves only when the coded decision forces a renormalization
  wire need_renorm = is_lps | (a_diff < `A_HALF); // [RULE3]
  wire ctx_we = accept & need_renorm; // [RULE2]
  wire [`IDX_W-1:0] new_state = is_lps ? successor_on_lps : successor_on_mps; // [RULE4] [RULE5]
  wire new_mps = context_mps_sense ^ (is_lps & sense_flip_flag); // [RULE5] [RULE6]

  ctx_store u_ctx (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(init_now),
    .we(ctx_we),
    .waddr(dec_ctx),
    .wstate(new_state),
    .wmps(new_mps),
    .raddr(dec_ctx),
    .rstate(ctx_state),
    .rmps(context_mps_sense),
    .paddr_peek(peek_sel_r),
    .peek_data(peek_data)
  );

  // one renormalization step
  wire [`A_W-1:0] a_shift = {interval_r[`A_W-2:0], 1'b0}; // [RULE8]
  wire [`C_W-1:0] c_shift = {code_r[`C_W-2:0], 1'b0}; // [RULE8]
  // the reload happens on the shift that empties the counter, so byte pulses stay eight shifts apart
  wire [`SHIFT_CNT_W-1:0] shift_cnt_dec = shift_counter_r - 4'h1;
  wire byte_due = (shift_cnt_dec == 4'h0); // [RULE9]

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      interval_r <= `A_INIT;
      code_r <= `C_INIT;
      shift_counter_r <= `SHIFT_CNT_INIT;
      byte_valid <= 1'b0;
      byte_data <= 9'h000;
    end else begin
      byte_valid <= 1'b0;
      if (init_now) begin
        // init aborts any renormalization in flight
        state_r <= S_IDLE;
        interval_r <= `A_INIT; // [RULE12]
        code_r <= `C_INIT; // [RULE12]
        shift_counter_r <= `SHIFT_CNT_INIT; // [RULE12]
      end else begin
        case (state_r)
          S_IDLE: begin
            if (accept) begin
              if (is_lps) begin
                code_r <= c_add; // [RULE13]
                interval_r <= {2'b00, lps_probability_estimate}; // [RULE13]
              end else begin
                interval_r <= a_diff; // [RULE13]
              end
              if (need_renorm) begin
                state_r <= S_RENORM;
              end
            end
          end
          S_RENORM: begin
            interval_r <= a_shift; // [RULE8]
            if (byte_due) begin
              // carry bit goes along so the output stage can resolve carry-over
              byte_valid <= 1'b1; // [RULE9]
              byte_data <= c_shift[`BYTE_MSB:`BYTE_LSB];
              code_r <= {{(`C_W-`BYTE_LSB){1'b0}}, c_shift[`BYTE_LSB-1:0]};
              shift_counter_r <= `SHIFT_CNT_RELOAD; // [RULE9]
            end else begin
              code_r <= c_shift;
              shift_counter_r <= shift_cnt_dec;
            end
            if (a_shift >= `A_HALF) begin
              state_r <= S_IDLE; // [RULE10]
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // register bus: zero wait states, unmapped addresses answer with an error
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_INTERVAL) ||
               (a == `REG_CODE) || (a == `REG_PEEK);
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = apb_acc & ~mapped(paddr);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      enable_r <= `CTRL_RESET;
      init_pend_r <= 1'b1;
      peek_sel_r <= {`CTX_W{1'b0}};
    end else begin
      // init runs one cycle after the write; reset also schedules one
      init_pend_r <= wr_ctrl & pwdata[`CTRL_INIT_BIT]; // [RULE11] [RULE12]
      if (wr_ctrl) begin
        enable_r <= pwdata[`CTRL_EN_BIT];
      end
      if (wr_peek) begin
        peek_sel_r <= pwdata[`CTX_W-1:0];
      end
    end
  end

  reg [31:0] rdata_nxt;

  // read word built every cycle, registered only on a read setup so prdata stands through the access phase
  always @* begin
    rdata_nxt = 32'h00000000;
    case (paddr)
      `REG_CTRL: begin
        rdata_nxt[`CTRL_EN_BIT] = enable_r;
      end
      `REG_STATUS: begin
        rdata_nxt[`STATUS_BUSY_BIT] = state_r[1] | init_pend_r;
        rdata_nxt[`STATUS_EN_BIT] = enable_r;
        rdata_nxt[`STATUS_SHIFT_LSB+`SHIFT_CNT_W-1:`STATUS_SHIFT_LSB] = shift_counter_r;
      end
      `REG_INTERVAL: begin
        rdata_nxt[`A_W-1:0] = interval_r;
      end
      `REG_CODE: begin
        rdata_nxt[`C_W-1:0] = code_r;
      end
      `REG_PEEK: begin
        // sense sits at bit 8, above the 7-bit state; bit 7 reads zero
        rdata_nxt[`PEEK_MPS_BIT] = peek_data[`IDX_W];
        rdata_nxt[`IDX_W-1:0] = peek_data[`IDX_W-1:0];
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ### testbench/arith_est_renorm_props.sv
// concurrent checks on the estimation and renormalization block ports
`timescale 1ns/1ps
`default_nettype none
`include "arith_est_map.vh"
module arith_est_renorm_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dec_valid,
  input wire logic dec_ready,
  input wire logic [`CTX_W-1:0] dec_ctx,
  input wire logic dec_bit,
  input wire logic byte_valid,
  input wire logic [8:0] byte_data
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // a reload of 8 keeps byte pulses at least eight edges apart
  byte_gap_a: assert property (byte_valid |=> !byte_valid [*7])
    else $error("byte pulses too close");
  byte_hold_a: assert property (!byte_valid |-> $stable(byte_data))
    else $error("byte data moved without a pulse");
  shift_only_a: assert property (byte_valid |-> !$past(dec_ready))
    else $error("byte left outside a shift sequence");
  // worst case is a one-count estimate, fifteen shifts
  renorm_bound_a: assert property ($fell(dec_ready) |-> ##[1:16] dec_ready)
    else $error("renormalization did not end");
  ready_reset_a: assert property (!$past(resetn) |-> !dec_ready)
    else $error("decision port open right after reset");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  slverr_data_a: assert property (psel && penable && pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("unmapped read returned data");
  ready_const_a: assert property (pready)
    else $error("wait state inserted");
  prdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read");
  cover property (byte_valid);
  cover property ($fell(dec_ready));
  cover property (psel && penable && pslverr);
endmodule
bind arith_est_renorm arith_est_renorm_props chk (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_ctx(dec_ctx), .dec_bit(dec_bit),
  .byte_valid(byte_valid), .byte_data(byte_data));
`default_nettype wire

// ### testbench/coder_partner.sv
// far-side model: issues coding decisions and collects output bytes
`timescale 1ns/1ps
`default_nettype none
`include "arith_est_map.vh"
module coder_partner (
  input wire logic sys_clk,
  input wire logic dec_ready,
  input wire logic byte_valid,
  input wire logic [8:0] byte_data,
  output var logic dec_valid,
  output var logic [`CTX_W-1:0] dec_ctx,
  output var logic dec_bit
);
  logic [8:0] got[$];
  initial begin
    dec_valid = 1'b0;
    dec_ctx = 6'h00;
    dec_bit = 1'b0;
  end
  // no back-pressure exists, so every pulse must be taken
  always @(posedge sys_clk) begin
    if (byte_valid) begin
      got.push_back(byte_data);
    end
  end
  task automatic send(input logic [`CTX_W-1:0] c, input logic b, output logic late);
    integer i;
    repeat ($urandom % 3) @(posedge sys_clk);
    dec_valid <= 1'b1;
    dec_ctx <= c;
    dec_bit <= b;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (dec_ready !== 1'b1 && i < 50);
    late = (i >= 50);
    // released lines go inverted so a stale request never looks valid
    dec_valid <= 1'b0;
    dec_ctx <= ~c;
    dec_bit <= ~b;
  endtask
endmodule
`default_nettype wire

// ### testbench/arith_est_renorm_bench.sv
// self-checking bench for the estimation and renormalization block
`timescale 1ns/1ps
`default_nettype none
`include "arith_est_map.vh"
module arith_est_renorm_bench;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, er, late;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic dec_valid, dec_ready, dec_bit, byte_valid;
  logic [5:0] dec_ctx;
  logic [8:0] byte_data;
  logic [8:0] expq[$];
  integer n_mismatch = 0, total_checks = 0, ma, mc, mct, c;
  integer ms[64], mm[64];
  arith_est_renorm dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dec_valid(dec_valid),
    .dec_ready(dec_ready), .dec_ctx(dec_ctx), .dec_bit(dec_bit), .byte_valid(byte_valid), .byte_data(byte_data));
  coder_partner far (.sys_clk(sys_clk), .dec_ready(dec_ready), .byte_valid(byte_valid), .byte_data(byte_data),
    .dec_valid(dec_valid), .dec_ctx(dec_ctx), .dec_bit(dec_bit));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    stop_test();
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    integer i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) hang();
  endtask
  task automatic idle;
    integer i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (dec_ready !== 1'b1 && i < 50);
    if (i >= 50) hang();
  endtask
  // partial estimator table {estimate, lps successor, mps successor, flip}; 0 marks a state not modelled
  function automatic integer tbl(input integer s);
    case (s)
      0: tbl = 32'h5A1D0103;
      1: tbl = 32'h25860E04;
      2: tbl = 32'h11141006;
      14: tbl = 32'h5A7F0F1F;
      default: tbl = 0;
    endcase
  endfunction
  task automatic minit;
    ma = 32'h00010000;
    mc = 0;
    mct = 11;
    for (int k = 0; k < 64; k++) begin
      ms[k] = 0;
      mm[k] = 0;
    end
  endtask
  task automatic mdec(input integer c, input integer b);
    integer t, q;
    t = tbl(ms[c]);
    q = t >> 16;
    if (b != mm[c]) begin
      mc = (mc + ma - q) & 32'h0FFFFFFF;
      ma = q;
      mm[c] = mm[c] ^ (t & 1);
      ms[c] = (t >> 8) & 255;
    end else begin
      ma = ma - q;
      if (ma < 32'h8000) ms[c] = (t >> 1) & 127;
    end
    while (ma < 32'h8000) begin
      ma = ma * 2;
      mc = (mc * 2) & 32'h0FFFFFFF;
      mct = mct - 1;
      if (mct == 0) begin
        expq.push_back(9'(mc >> 19));
        mc = mc & 32'h0007FFFF;
        mct = 8;
      end
    end
  endtask
  task automatic verify(input integer c);
    apb(8'h08, 1'b0, 32'h0);
    check(rd, ma, "interval");
    apb(8'h0C, 1'b0, 32'h0);
    check(rd, mc, "code");
    apb(8'h04, 1'b0, 32'h0);
    check(rd[11:8], mct, "shift counter");
    apb(8'h10, 1'b1, c);
    apb(8'h10, 1'b0, 32'h0);
    check(rd, (mm[c] << 8) | ms[c], "context");
  endtask
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(3613));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    minit();
    verify(5);
    apb(8'h20, 1'b0, 32'h0);
    check(er, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(8'h00, 1'b1, 32'h00000002);
    $display("test reset done");
    for (int n = 0; n < 400; n++) begin
      c = $urandom % 64;
      if (tbl(ms[c]) == 0) begin
        // a context past the modelled states forces a fresh start
        apb(8'h00, 1'b1, 32'h00000003);
        minit();
        idle();
        verify(c);
        $display("test init done");
      end else begin
        er = 1'($urandom % 2);
        far.send(c[5:0], er, late);
        if (late) hang();
        mdec(c, er);
        idle();
        verify(c);
      end
    end
    $display("test random decisions done");
    check(far.got.size(), expq.size(), "byte count");
    foreach (expq[k]) begin
      if (k < far.got.size()) check(far.got[k], expq[k], "byte");
    end
    $display("test bytes done");
    stop_test();
  end
endmodule
`default_nettype wire
